// [usp_top.sv]
`timescale 1ns/1ps
// Functional notes
// - Drive reset line low on any reset
// - External reset needs 15 us low
// - Drop D+ pull-up without VBUS, self-powered
// - Status asserts during host bus reset
// - Status asserts while suspended
// - Low power budget: suspend only
// - High power budget: suspend or unconfigured
// - Polarity and conditions are configurable
// - Inactive level when no condition true
// - Default active high, suspend only
// - First modem pin: GPIO out or ready-in
// - Second modem pin: GPIO out or ready-out
// - Third modem pin: GPIO in, ring, wake
// - Pin modes revert on POR, bus reset
module usp_top
  import usp_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  input  wire logic                  reg_reset_req,
  input  wire logic                  usb_bus_reset,
  input  wire logic                  usb_suspended,
  input  wire logic                  usb_configured,
  input  wire logic                  self_powered,
  input  wire logic [7:0]            max_power,
  input  wire logic                  bus_power_sense,
  output logic                       dplus_pullup_en,
  output logic                       device_reset,
  input  wire logic                  reset_line_in,
  output logic                       reset_line_out,
  output logic                       reset_line_oe,
  input  wire logic                  stat_cfg_we,
  input  wire logic [STAT_CFG_W-1:0] stat_cfg_wdata,
  output logic [STAT_CFG_W-1:0]      status_pin_config,
  output logic                       usb_state_indicator_out,
  output logic                       usb_state_indicator_oe,
  input  wire logic                  pin_mode_we,
  input  wire logic [PIN_MODE_W-1:0] ready_in_mode_wdata,
  input  wire logic [PIN_MODE_W-1:0] ready_out_mode_wdata,
  input  wire logic [PIN_MODE_W-1:0] ring_wake_mode_wdata,
  output logic [PIN_MODE_W-1:0]      ready_in_mode,
  output logic [PIN_MODE_W-1:0]      ready_out_mode,
  output logic [PIN_MODE_W-1:0]      ring_wake_mode,
  input  wire logic                  gpio9_out_val,
  input  wire logic                  dtr_active,
  input  wire logic                  gpio8_out_val,
  input  wire logic                  modem_ready_input_pin_in,
  output logic                       modem_ready_input_pin_out,
  output logic                       modem_ready_input_pin_oe,
  input  wire logic                  terminal_ready_output_pin_in,
  output logic                       terminal_ready_output_pin_out,
  output logic                       terminal_ready_output_pin_oe,
  input  wire logic                  ring_or_wake_input_pin_in,
  output logic                       ring_or_wake_input_pin_out,
  output logic                       ring_or_wake_input_pin_oe,
  output logic                       ring_or_wake_pullup_en,
  output logic                       dsr_asserted,
  output logic                       ring_asserted,
  output logic                       wake_request,
  output logic                       gpio7_in_val,
  output logic                       gpio9_in_val
);
  // Synchronised pin levels, DTR readback taken raw
  logic rst_pin_s;        // Reset line, high when idle
  logic vbus_s;           // Bus power sense
  logic dsr_pin_s;        // First modem pin input
  logic ri_pin_s;         // Third modem pin input
  logic dtr_pin_s;        // Unused readback path is not kept

  usp_sync #(.RESET_VAL(1'b1)) u_sync_rst
  (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .d_in    (reset_line_in),
    .q_out   (rst_pin_s)
  );

  usp_sync #(.RESET_VAL(1'b0)) u_sync_vbus
  (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .d_in    (bus_power_sense),
    .q_out   (vbus_s)
  );

  usp_sync #(.RESET_VAL(1'b1)) u_sync_dsr
  (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .d_in    (modem_ready_input_pin_in),
    .q_out   (dsr_pin_s)
  );

  usp_sync #(.RESET_VAL(1'b1)) u_sync_ri
  (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .d_in    (ring_or_wake_input_pin_in),
    .q_out   (ri_pin_s)
  );

  // Reset line sequencer state
  usp_rst_state_e         rst_state_reg;   // Sequencer state
  usp_rst_state_e         rst_state_next;
  logic [RST_CNT_W-1:0]   low_cnt_reg;     // External low pulse width
  logic [RST_CNT_W-1:0]   low_cnt_next;
  logic [RST_CNT_W-1:0]   drv_cnt_reg;     // Drive-low time left
  logic [RST_CNT_W-1:0]   drv_cnt_next;
  logic                   ext_rst_hit;     // Pulse long enough

  // External pulse counts only while we are not driving the line ourselves,
  // otherwise our own drive would look like an external reset
  assign ext_rst_hit = (rst_state_reg == USP_RST_IDLE) && !rst_pin_s &&
                       (low_cnt_reg >= (RST_CNT_MIN - RST_CNT_ONE));

  // Next state for the reset sequencer
  always_comb
  begin
    rst_state_next = rst_state_reg;
    low_cnt_next   = low_cnt_reg;
    drv_cnt_next   = drv_cnt_reg;
    case (rst_state_reg)
      USP_RST_IDLE:
      begin
        // Saturating width counter, cleared on release
        if (rst_pin_s)
          low_cnt_next = RST_CNT_ZERO;
        else if (low_cnt_reg != {RST_CNT_W{1'b1}})
          low_cnt_next = low_cnt_reg + RST_CNT_ONE;
        // Any reset source starts a drive phase
        if (reg_reset_req || usb_bus_reset || ext_rst_hit)
        begin
          rst_state_next = USP_RST_DRIVE;
          drv_cnt_next   = RST_DRIVE_CYC;
        end
      end
      USP_RST_DRIVE:
      begin
        // Hold while bus reset lasts, then count down
        if (usb_bus_reset)
          drv_cnt_next = RST_DRIVE_CYC;
        else if (drv_cnt_reg != RST_CNT_ZERO)
          drv_cnt_next = drv_cnt_reg - RST_CNT_ONE;
        else
          rst_state_next = USP_RST_WAIT;
      end
      USP_RST_WAIT:
      begin
        // Wait for the line to float back high before re-arming
        low_cnt_next = RST_CNT_ZERO;
        if (rst_pin_s)
          rst_state_next = USP_RST_IDLE;
      end
      default:
      begin
        rst_state_next = USP_RST_IDLE;
      end
    endcase
    if (!rst_b)
    begin
      // Power-on: start in drive so the line pulses low
      rst_state_next = USP_RST_DRIVE;
      low_cnt_next   = RST_CNT_ZERO;
      drv_cnt_next   = RST_DRIVE_CYC;
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_sys)
  begin
    rst_state_reg <= rst_state_next;
    low_cnt_reg   <= low_cnt_next;
    drv_cnt_reg   <= drv_cnt_next;
  end

  // Open drain: drive low only while in drive phase
  assign reset_line_out = 1'b0;
  assign reset_line_oe  = (rst_state_reg == USP_RST_DRIVE);
  assign device_reset   = (rst_state_reg == USP_RST_DRIVE);

  // Configuration state
  logic [STAT_CFG_W-1:0] stat_cfg_reg;   // Status pin config
  logic [STAT_CFG_W-1:0] stat_cfg_next;
  logic [PIN_MODE_W-1:0] mode9_reg;      // First modem pin mode
  logic [PIN_MODE_W-1:0] mode9_next;
  logic [PIN_MODE_W-1:0] mode8_reg;      // Second modem pin mode
  logic [PIN_MODE_W-1:0] mode8_next;
  logic [PIN_MODE_W-1:0] mode7_reg;      // Third modem pin mode
  logic [PIN_MODE_W-1:0] mode7_next;
  logic                  cfg_clear;      // Reset of the three pin modes

  assign cfg_clear = !rst_b || usb_bus_reset || device_reset;

  // Next values for config; the clear wins, as the lost config is intended
  always_comb
  begin
    stat_cfg_next = stat_cfg_reg;
    mode9_next    = mode9_reg;
    mode8_next    = mode8_reg;
    mode7_next    = mode7_reg;
    if (stat_cfg_we)
      stat_cfg_next = stat_cfg_wdata;
    if (pin_mode_we)
    begin
      // Illegal codes fall back to GPIO on the two-mode pins
      mode9_next = (ready_in_mode_wdata == MODE_ALT1) ? MODE_ALT1 : MODE_GPIO;
      mode8_next = (ready_out_mode_wdata == MODE_ALT1) ? MODE_ALT1 : MODE_GPIO;
      mode7_next = (ring_wake_mode_wdata == MODE_ALT1 ||
                    ring_wake_mode_wdata == MODE_ALT2) ? ring_wake_mode_wdata : MODE_GPIO;
    end
    // Status config survives bus reset, else its bus reset select could never act
    if (!rst_b)
      stat_cfg_next = STAT_CFG_RESET;
    if (cfg_clear)
    begin
      mode9_next    = MODE_GPIO;
      mode8_next    = MODE_GPIO;
      mode7_next    = MODE_GPIO;
    end
  end

  // Config registers
  always_ff @(posedge clk_sys)
  begin
    stat_cfg_reg <= stat_cfg_next;
    mode9_reg    <= mode9_next;
    mode8_reg    <= mode8_next;
    mode7_reg    <= mode7_next;
  end

  assign status_pin_config = stat_cfg_reg;
  assign ready_in_mode     = mode9_reg;
  assign ready_out_mode    = mode8_reg;
  assign ring_wake_mode    = mode7_reg;

  // Status condition evaluation
  logic pwr_cond;     // Not safe to draw power
  logic stat_active;  // Any selected condition true
  logic stat_reg;     // Registered pin level
  logic stat_next;
  logic pull_reg;     // D+ pull-up enable
  logic pull_next;

  // High power devices also flag until configured
  assign pwr_cond = (max_power > MAX_POWER_LOW_LIMIT) ?
                    (usb_suspended || !usb_configured) :
                    usb_suspended;

  assign stat_active =
    (stat_cfg_reg[STAT_SEL_RST_BIT] && usb_bus_reset) ||
    (stat_cfg_reg[STAT_SEL_SUS_BIT] && usb_suspended) ||
    (stat_cfg_reg[STAT_SEL_PWR_BIT] && pwr_cond);

  // Next pin level and pull-up
  always_comb
  begin
    // Inactive level is the inverse of the active polarity
    stat_next = stat_active ? stat_cfg_reg[STAT_POL_BIT] :
                              !stat_cfg_reg[STAT_POL_BIT];
    // Bus-powered parts always see VBUS, so only self-powered gates it
    pull_next = self_powered ? vbus_s : 1'b1;
    if (!rst_b)
    begin
      stat_next = !STAT_CFG_RESET[STAT_POL_BIT];
      pull_next = 1'b0;
    end
  end

  // Status registers
  always_ff @(posedge clk_sys)
  begin
    stat_reg <= stat_next;
    pull_reg <= pull_next;
  end

  // Open drain: drive only the low level, weak pull-up gives the high
  assign usb_state_indicator_out = 1'b0;
  assign usb_state_indicator_oe  = !stat_reg;
  assign dplus_pullup_en         = pull_reg;

  // Modem pin drivers
  logic [2:0] pin_out_reg;   // Output levels for pins 9, 8, 7
  logic [2:0] pin_out_next;

  // Next output levels
  always_comb
  begin
    pin_out_next[0] = gpio9_out_val;
    pin_out_next[1] = (mode8_reg == MODE_ALT1) ? !dtr_active : gpio8_out_val;
    pin_out_next[2] = 1'b1;
    if (!rst_b)
      pin_out_next = 3'h3;
  end

  // Output level registers
  always_ff @(posedge clk_sys)
  begin
    pin_out_reg <= pin_out_next;
  end

  assign modem_ready_input_pin_out     = pin_out_reg[0];
  assign modem_ready_input_pin_oe      = (mode9_reg == MODE_GPIO);
  assign terminal_ready_output_pin_out = pin_out_reg[1];
  assign terminal_ready_output_pin_oe  = 1'b1;
  assign ring_or_wake_input_pin_out    = pin_out_reg[2];
  assign ring_or_wake_input_pin_oe     = 1'b0;
  assign ring_or_wake_pullup_en        = 1'b1;

  // Input decodes, active low functions
  assign dsr_asserted  = (mode9_reg == MODE_ALT1) && !dsr_pin_s;
  assign ring_asserted = (mode7_reg == MODE_ALT1) && !ri_pin_s;
  assign wake_request  = (mode7_reg == MODE_ALT2) && !ri_pin_s;
  assign gpio7_in_val  = ri_pin_s;
  assign gpio9_in_val  = dsr_pin_s;
  assign dtr_pin_s     = terminal_ready_output_pin_in;
endmodule

// [usp_pkg.sv]
package usp_pkg;
  // Core clock rate
  localparam int unsigned CLK_HZ           = 10_000_000;
  // Least external reset pulse, in ns
  localparam int unsigned EXT_RST_MIN_NS   = 15_000;
  // Least pulse in cycles, rounded up
  localparam int unsigned EXT_RST_MIN_CYC  =
    (EXT_RST_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Width of the pulse counter
  localparam int unsigned RST_CNT_W        = 8;
  localparam logic [RST_CNT_W-1:0] RST_CNT_MIN = RST_CNT_W'(EXT_RST_MIN_CYC);
  // Drive-low count load; the reset line is driven low for one cycle more than this
  localparam logic [RST_CNT_W-1:0] RST_DRIVE_CYC = 8'h10;
  localparam logic [RST_CNT_W-1:0] RST_CNT_ZERO  = 8'h00;
  localparam logic [RST_CNT_W-1:0] RST_CNT_ONE   = 8'h01;

  // Power budget threshold for the max power field
  localparam logic [7:0] MAX_POWER_LOW_LIMIT = 8'h32;

  // Status pin config fields
  localparam int unsigned STAT_CFG_W       = 4;
  localparam int unsigned STAT_POL_BIT     = 0;  // 1 = active high
  localparam int unsigned STAT_SEL_RST_BIT = 1;  // Bus reset condition
  localparam int unsigned STAT_SEL_SUS_BIT = 2;  // Suspend condition
  localparam int unsigned STAT_SEL_PWR_BIT = 3;  // Power budget condition
  // Default: active high, suspend only
  localparam logic [STAT_CFG_W-1:0] STAT_CFG_RESET = 4'h5;

  // Modem pin modes
  localparam int unsigned PIN_MODE_W       = 2;
  localparam logic [PIN_MODE_W-1:0] MODE_GPIO    = 2'h0;
  localparam logic [PIN_MODE_W-1:0] MODE_ALT1    = 2'h1;
  localparam logic [PIN_MODE_W-1:0] MODE_ALT2    = 2'h2;

  // Reset line sequencer states, Gray except on the wait to idle return
  typedef enum logic [1:0] {
    USP_RST_IDLE  = 2'b00,
    USP_RST_DRIVE = 2'b01,
    USP_RST_WAIT  = 2'b11
  } usp_rst_state_e;
endpackage

// [usp_sync.sv]
`timescale 1ns/1ps
// Two flop synchroniser for one level
module usp_sync
  import usp_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
)
(
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic d_in,
  output logic      q_out
);
  logic meta_reg;   // First stage, read by second only
  logic sync_reg;   // Second stage
  logic meta_next;
  logic sync_next;

  // Next values: shift one stage
  always_comb
  begin
    meta_next = d_in;
    sync_next = meta_reg;
    if (!rst_b)
    begin
      meta_next = RESET_VAL;
      sync_next = RESET_VAL;
    end
  end

  // Registers only
  always_ff @(posedge clk_sys)
  begin
    meta_reg <= meta_next;
    sync_reg <= sync_next;
  end

  assign q_out = sync_reg;
endmodule

// [usp_host_model.sv]
`timescale 1ns/1ps
// Host link state and external reset source
module usp_host_model (
  input  wire logic clk_sys,
  input  wire logic reset_line_oe,
  output logic      reset_line_in,
  output logic      usb_bus_reset,
  output logic      usb_suspended,
  output logic      usb_configured,
  output logic      bus_power_sense
);
  logic ext_low = 1'b0; // Outside party pulls line
  // Idle host: configured, VBUS present
  initial {usb_bus_reset, usb_suspended, usb_configured, bus_power_sense} = 4'h3;
  // Pull-up wins only when nobody drives low
  assign reset_line_in = !(reset_line_oe || ext_low);
  // Suspend, configured and VBUS levels
  task automatic set_link(input logic s, input logic c, input logic v);
    @(posedge clk_sys);
    {usb_suspended, usb_configured, bus_power_sense} <= {s, c, v};
  endtask
  // Bus reset held for n cycles
  task automatic bus_reset(input int n);
    @(posedge clk_sys);
    usb_bus_reset <= 1'b1;
    repeat (n) @(posedge clk_sys);
    usb_bus_reset <= 1'b0;
  endtask
  // Low pulse of n cycles; short ones on purpose only
  task automatic ext_pulse(input int n);
    @(posedge clk_sys);
    ext_low <= 1'b1;
    repeat (n) @(posedge clk_sys);
    ext_low <= 1'b0;
  endtask
endmodule

// [usp_top_props.sv]
`timescale 1ns/1ps
// Port level checks of the pin logic
module usp_top_props
  import usp_pkg::*;
(
  input wire logic                  clk_sys,
  input wire logic                  rst_b,
  input wire logic                  reg_reset_req,
  input wire logic                  usb_bus_reset,
  input wire logic                  usb_suspended,
  input wire logic                  usb_configured,
  input wire logic                  self_powered,
  input wire logic [7:0]            max_power,
  input wire logic                  bus_power_sense,
  input wire logic                  dplus_pullup_en,
  input wire logic                  device_reset,
  input wire logic                  reset_line_in,
  input wire logic                  reset_line_oe,
  input wire logic [STAT_CFG_W-1:0] status_pin_config,
  input wire logic                  usb_state_indicator_oe,
  input wire logic [PIN_MODE_W-1:0] ready_in_mode,
  input wire logic [PIN_MODE_W-1:0] ready_out_mode,
  input wire logic [PIN_MODE_W-1:0] ring_wake_mode,
  input wire logic                  dtr_active,
  input wire logic                  stat_cfg_we,
  input wire logic                  terminal_ready_output_pin_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic       idle, cond, lvl; // Quiet line, status terms
  logic [7:0] low_reg;         // Low run not driven by us
  logic [7:0] low_next;
  assign idle = !reset_line_oe && !device_reset && reset_line_in;
  assign cond = (status_pin_config[STAT_SEL_RST_BIT] && usb_bus_reset)
    || (status_pin_config[STAT_SEL_SUS_BIT] && usb_suspended)
    || (status_pin_config[STAT_SEL_PWR_BIT] && (usb_suspended
    || (max_power > MAX_POWER_LOW_LIMIT && !usb_configured)));
  assign lvl = cond ~^ status_pin_config[STAT_POL_BIT];
  // Saturates so a stuck line cannot wrap to a short count
  always_comb
  begin
    low_next = low_reg + {7'h00, low_reg != 8'hff};
    if (reset_line_in || reset_line_oe)
      low_next = 8'h00;
  end
  // Reset time lows never count
  always_ff @(posedge clk_sys)
    low_reg <= rst_b ? low_next : 8'h00;
  sequence s_drive;
    reset_line_oe[*8] ##1 reset_line_oe[*8] ##1 reset_line_oe;
  endsequence
  property p_req;
    (reg_reset_req || usb_bus_reset) && idle && $past(idle, 2) && $past(idle, 4)
      |=> reset_line_oe && device_reset;
  endproperty
  a_req: assert property (p_req) else $error("no drive on request");
  property p_len;
    $rose(reset_line_oe) && !usb_bus_reset |-> s_drive ##1 !reset_line_oe;
  endproperty
  a_len: assert property (p_len) else $error("drive length wrong");
  property p_clear;
    device_reset |=> {ready_in_mode, ready_out_mode, ring_wake_mode} == 6'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("config kept");
  property p_keep;
    device_reset && !stat_cfg_we |=> $stable(status_pin_config);
  endproperty
  a_keep: assert property (p_keep) else $error("status config lost");
  property p_pull;
    (self_powered && !bus_power_sense)[*4] |-> !dplus_pullup_en;
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up on");
  property p_stat;
    !device_reset && $stable(lvl) |=> usb_state_indicator_oe != $past(lvl);
  endproperty
  a_stat: assert property (p_stat) else $error("status level");
  property p_short;
    $rose(reset_line_oe) && !$past(reg_reset_req) && !$past(usb_bus_reset)
      |-> $past(low_reg) > 8'h8c;
  endproperty
  a_short: assert property (p_short) else $error("short pulse");
  property p_long;
    !reset_line_in |-> low_reg < 8'ha0;
  endproperty
  a_long: assert property (p_long) else $error("long pulse ignored");
  property p_dtr;
    ready_out_mode == MODE_ALT1 && $stable(ready_out_mode)
      |=> terminal_ready_output_pin_out == !$past(dtr_active);
  endproperty
  a_dtr: assert property (p_dtr) else $error("ready out level");
endmodule
bind usp_top usp_top_props chk_u (.*);

// [usp_top_bench.sv]
`timescale 1ns/1ps
// Self-checking bench for the pin logic
module usp_top_bench
  import usp_pkg::*;
;
  logic clk_sys = 1'b0, rst_b = 1'b0, reg_reset_req = 1'b0, self_powered = 1'b0;
  logic stat_cfg_we = 1'b0, pin_mode_we = 1'b0, dtr_active = 1'b0, dsr_drv = 1'b1;
  logic gpio9_out_val = 1'b0, gpio8_out_val = 1'b0, ri_drv = 1'b1;
  logic [7:0] max_power = 8'h32;
  logic [STAT_CFG_W-1:0] stat_cfg_wdata = 4'h0, status_pin_config;
  logic [PIN_MODE_W-1:0] ready_in_mode_wdata = 2'h0, ready_out_mode_wdata = 2'h0;
  logic [PIN_MODE_W-1:0] ring_wake_mode_wdata = 2'h0, ready_in_mode, ready_out_mode;
  logic [PIN_MODE_W-1:0] ring_wake_mode;
  logic usb_bus_reset, usb_suspended, usb_configured, bus_power_sense, reset_line_in;
  logic dplus_pullup_en, device_reset, reset_line_out, reset_line_oe, dsr_asserted;
  logic usb_state_indicator_out, usb_state_indicator_oe, ring_asserted, wake_request;
  logic modem_ready_input_pin_in, modem_ready_input_pin_out, modem_ready_input_pin_oe;
  logic terminal_ready_output_pin_in, terminal_ready_output_pin_out;
  logic terminal_ready_output_pin_oe, ring_or_wake_input_pin_in;
  logic ring_or_wake_input_pin_out, ring_or_wake_input_pin_oe;
  logic ring_or_wake_pullup_en, gpio7_in_val, gpio9_in_val;
  int   fail_count = 0;
  int   checked = 0;
  // Pin wires resolved from who drives them
  assign modem_ready_input_pin_in = modem_ready_input_pin_oe ? modem_ready_input_pin_out : dsr_drv;
  assign terminal_ready_output_pin_in = terminal_ready_output_pin_out;
  assign ring_or_wake_input_pin_in = ring_or_wake_input_pin_oe ? ring_or_wake_input_pin_out : ri_drv;
  usp_top dut_u (.*);
  usp_host_model host_u (.*);
  always #50 clk_sys = ~clk_sys;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Checks at the falling edge, well after updates land
  task automatic settle(input int n);
    cyc(n);
    @(negedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  // Status config and all three pin modes in one strobe
  task automatic wr(input logic [3:0] cfg, input logic [5:0] md);
    cyc(1);
    stat_cfg_we <= 1'b1;
    pin_mode_we <= 1'b1;
    stat_cfg_wdata <= cfg;
    {ready_in_mode_wdata, ready_out_mode_wdata, ring_wake_mode_wdata} <= md;
    cyc(1);
    stat_cfg_we <= 1'b0;
    pin_mode_we <= 1'b0;
  endtask
  task automatic chk_dflt(input string nm, input logic [3:0] cfg);
    chk(nm, {cfg, 4'h0}, {status_pin_config, ready_in_mode, ready_out_mode});
    chk(nm, 8'h00, ring_wake_mode);
  endtask
  task automatic t_dflt;
    settle(30);
    chk_dflt("defaults", 4'h5);
    chk("pins", 8'h69, {modem_ready_input_pin_oe, terminal_ready_output_pin_oe,
      ring_or_wake_input_pin_oe, ring_or_wake_pullup_en, reset_line_out,
      usb_state_indicator_out, ring_or_wake_input_pin_out});
    chk("stat idle", 8'h01, usb_state_indicator_oe);
  endtask
  // Every config against suspend, configured and budget
  task automatic t_stat;
    logic cond;
    for (int c = 0; c < 16; c++)
    begin
      wr(c[3:0], 6'h00);
      for (int k = 0; k < 8; k++)
      begin
        host_u.set_link(k[0], k[1], 1'b1);
        max_power <= k[2] ? 8'h33 : 8'h32;
        settle(1);
        cond = (c[2] && k[0]) || (c[3] && (k[0] || (k[2] && !k[1])));
        chk("stat", {7'h00, cond ^ c[0]}, usb_state_indicator_oe);
      end
    end
    host_u.set_link(1'b0, 1'b1, 1'b1);
  endtask
  task automatic t_pull;
    host_u.set_link(1'b0, 1'b1, 1'b0);
    self_powered <= 1'b1;
    settle(5);
    chk("pullup off", 8'h00, dplus_pullup_en);
    host_u.set_link(1'b0, 1'b1, 1'b1);
    settle(5);
    chk("pullup on", 8'h01, dplus_pullup_en);
  endtask
  // Software reset must undo written pin modes but keep the status config
  task automatic t_soft;
    wr(4'hf, 6'h19);
    settle(0);
    chk("written", 8'hf4, {status_pin_config, ready_in_mode, ready_out_mode});
    cyc(1);
    reg_reset_req <= 1'b1;
    cyc(1);
    reg_reset_req <= 1'b0;
    settle(0);
    chk("soft drive", 8'h03, {reset_line_oe, device_reset});
    settle(30);
    chk_dflt("soft clear", 4'hf);
  endtask
  task automatic t_bus;
    wr(4'hf, 6'h19);
    host_u.bus_reset(40);
    settle(0);
    chk("bus drive", 8'h03, {reset_line_oe, device_reset});
    chk_dflt("bus clear", 4'hf);
    chk("bus stat", 8'h00, usb_state_indicator_oe);
    settle(30);
    chk("bus stat off", 8'h01, usb_state_indicator_oe);
  endtask
  // Too short is ignored, long enough resets
  task automatic t_ext;
    host_u.ext_pulse(60);
    settle(5);
    chk("short pulse", 8'h00, reset_line_oe);
    host_u.ext_pulse(158);
    settle(0);
    chk("long pulse", 8'h03, {reset_line_oe, device_reset});
    settle(40);
  endtask
  task automatic t_pins;
    wr(4'h5, 6'h15);
    dsr_drv <= 1'b0;
    ri_drv <= 1'b0;
    dtr_active <= 1'b1;
    settle(4);
    chk("alt pins", 8'h06, {modem_ready_input_pin_oe, terminal_ready_output_pin_out,
      dsr_asserted, ring_asserted, wake_request});
    wr(4'h5, 6'h02);
    gpio9_out_val <= 1'b1;
    gpio8_out_val <= 1'b1;
    settle(4);
    chk("gpio pins", 8'h79, {modem_ready_input_pin_oe, modem_ready_input_pin_out,
      terminal_ready_output_pin_out, wake_request, gpio7_in_val, dsr_asserted,
      gpio9_in_val});
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    cyc(4);
    rst_b <= 1'b1;
    t_dflt();
    t_stat();
    t_pull();
    t_soft();
    t_bus();
    t_ext();
    t_pins();
    tally_and_finish();
  end
  // Nearly thirty times the expected run
  initial
  begin
    #2000000;
    fail_count++;
    tally_and_finish();
  end
endmodule
